// ---- flash_bus_cycle.sv ----
// One timed read or write cycle on the flash pins, paced by a phase divider.
`timescale 1ns/1ps
module flash_bus_cycle
   import flash_host_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              go,
   input  wire logic              is_write,
   input  wire bus_word_t         word,
   input  wire logic [DATA_W-1:0] data_in,
   output pins_t                  pins,
   output logic [DATA_W-1:0]      rdata_q,
   output logic                   done
);

   // Cycle phases, Gray coded along setup, strobe, hold.
   typedef enum logic [1:0] {B_IDLE = 2'b00, B_SETUP = 2'b01, B_STROBE = 2'b11,
                             B_HOLD = 2'b10} bstate_t;

   bstate_t           state_q;     // Current phase.
   logic [3:0]        div_q;       // Phase divider.
   logic              tick;        // One-cycle enable at the end of each phase.
   logic              wr_q;        // Latched direction.
   bus_word_t         word_q;      // Latched address and data.

   assign tick = (state_q != B_IDLE) && (div_q == 4'(PHASE_CYC - 1));
   assign done = tick && (state_q == B_HOLD);

   // The divider restarts at every phase so each phase lasts exactly PHASE_CYC cycles.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst) div_q <= 4'h0;
      else if (state_q == B_IDLE || tick) div_q <= 4'h0;
      else div_q <= div_q + 4'h1;
   end

   // Phase sequencing; a go while busy is ignored, so the caller waits for done.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= B_IDLE;
         wr_q    <= 1'b0;
         word_q  <= '0;
      end
      else
      begin
         case (state_q)
            B_IDLE:
               if (go)
               begin
                  state_q <= B_SETUP;
                  wr_q    <= is_write;
                  word_q  <= word;
               end
            B_SETUP:  if (tick) state_q <= B_STROBE;
            B_STROBE: if (tick) state_q <= B_HOLD;
            default:  if (tick) state_q <= B_IDLE;
         endcase
      end
   end

   // Read data is caught at the end of the strobe phase, while output drive is still on.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst) rdata_q <= '0;
      else if (tick && state_q == B_STROBE && !wr_q) rdata_q <= data_in;
   end

   // Chip select stays high between cycles, which leaves the device in standby.
   always_comb
   begin
      pins.ce_n      = (state_q == B_IDLE);
      pins.we_n      = !(state_q == B_STROBE && wr_q);
      pins.oe_n      = !(state_q == B_STROBE && !wr_q);
      pins.addr      = word_q.addr;
      pins.dout      = word_q.data;
      pins.dout_oe_n = !(state_q != B_IDLE && wr_q);
   end

   // A cycle runs through its three phases.
   sequence s_cycle;
      (state_q == B_SETUP) ##[1:8] (state_q == B_STROBE) ##[1:8] done;
   endsequence

   a_write_strobe_frame: assert property (@(posedge clock) disable iff (!nrst)
      !pins.we_n |-> !pins.ce_n && pins.oe_n && !pins.dout_oe_n)
      else $error("write strobe outside a selected, driven cycle");
   a_read_drive_frame: assert property (@(posedge clock) disable iff (!nrst)
      !pins.oe_n |-> !pins.ce_n && pins.we_n && pins.dout_oe_n)
      else $error("output drive while host drives data lines");
   a_cycle_bound: assert property (@(posedge clock) disable iff (!nrst)
      (state_q == B_IDLE && go) |=> s_cycle)
      else $error("bus cycle did not finish in time");

endmodule

// ---- flash_dev_model.sv ----
// Behavioural byte-wide boot-sector flash device that answers the host controller's pins.
`timescale 1ns/1ps
module flash_dev_model
   import flash_host_pkg::*;
(
   input  wire logic              clock,
   input  wire pins_t             pins,
   input  wire logic              reset_n,
   input  wire logic              slow,
   input  wire logic              low_supply,
   output logic [DATA_W-1:0]      data_lines,
   output logic                   ready_pin
);
   logic [DATA_W-1:0] mem [0:262143]; // One byte per location, erased state is ff.
   localparam bit          TOP_BOOT = 1'b0;   // Bottom-boot variant is modelled.
   localparam logic [6:0]  PROT     = 7'h20;  // Sector 5 is locked against change.
   int                step = 0;       // Position inside a written command sequence.
   int                cnt = 0;        // Cycles left of the running embedded algorithm.
   int                save = 0;       // Erase time parked while suspended.
   logic              byp = 0;        // Bypass programming mode.
   logic              ers = 0;        // An erase is in progress.
   logic              susp = 0;       // The erase is on hold.
   logic              tog = 0;        // Status bit that flips on each busy read.
   logic [DATA_W-1:0] last = 8'h00;   // Byte of the latest read.
   logic [DATA_W-1:0] pd = 8'hff;     // Data whose bit 7 is inverted while busy.

   initial
   begin
      for (int i = 0; i < 262144; i++) mem[i] = 8'hff;
   end

   // seven sectors; the small ones sit at the boot end.
   function automatic int sector(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] b;
      b = TOP_BOOT ? ~a : a;
      if (b[17:16] != 2'h0) return 3 + int'(b[17:16]);
      else if (b[15]) return 3;
      else if (b[14]) return b[13] ? 2 : 1;
      else return 0;
   endfunction

   // Decode one captured write; cells only go from 1 to 0 when programmed.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      if (step == 9)
      begin
         if (!PROT[sector(a)]) mem[a] = mem[a] & d;
         pd = d;
         cnt = slow ? 40 : 4;
         step = 0;
      end
      else if (d == CODE_RESET) step = 0;
      else if (byp && d == CODE_PROG) step = 9;
      else if (byp && d == CODE_BEXIT) step = 8;
      else if (step == 8)
      begin
         byp = 1'b0;
         step = 0;
      end
      else if (ers && !susp && d == CODE_SUSP)
      begin
         save = cnt;
         cnt = 2;
         susp = 1'b1;
      end
      else if (susp && d == CODE_RESM)
      begin
         cnt = save;
         susp = 1'b0;
      end
      else if ((step == 0 || step == 3) && a == UNLOCK_A1 && d == KEY_1) step++;
      else if ((step == 1 || step == 4) && a == UNLOCK_A2 && d == KEY_2) step++;
      else if (step == 2 && d == CODE_PROG) step = 9;
      else if (step == 2 && d == CODE_BYP)
      begin
         byp = 1'b1;
         step = 0;
      end
      else if (step == 2 && d == CODE_ERASE) step = 3;
      else if (step == 5 && (d == CODE_CHIP || d == CODE_SECT))
      begin
         // only the chosen, unlocked sectors are wiped.
         for (int i = 0; i < 262144; i++)
            if ((d == CODE_CHIP || sector(18'(i)) == sector(a)) && !PROT[sector(18'(i))])
               mem[i] = 8'hff;
         ers = 1'b1;
         pd = 8'hff;
         cnt = slow ? 200 : 20;
         step = 0;
      end
      else step = 0;
   endtask

   // write capture at strobe end; a low supply drops it.
   always @(posedge pins.we_n)
   begin
      if (pins.ce_n === 1'b0 && reset_n === 1'b1 && low_supply !== 1'b1)
         wr(pins.addr, pins.dout);
   end

   always @(posedge clock)
   begin
      if (reset_n !== 1'b1) {cnt, step, byp, ers, susp} = '0;
      else if (cnt > 0) cnt--;
      else if (!susp) ers = 0;
   end

   // status or array byte on reads
   always @(negedge pins.oe_n)
   begin
      if (pins.ce_n === 1'b0)
      begin
         if (cnt != 0) tog = ~tog;
         last = (cnt != 0) ? {~pd[7], tog, 6'h00} : mem[pins.addr];
      end
   end

   // A released bus shows the inverse, never a stale copy of the last byte.
   assign data_lines = (pins.ce_n === 1'b0 && pins.oe_n === 1'b0) ? last : ~last;
   assign ready_pin  = (cnt == 0);
endmodule

// ---- flash_host_ctrl.sv ----
// Host controller that drives a byte-wide boot-sector flash through its pins.
//
// Functional notes
// - Commands are written as ordinary bus writes.
// - Bypass program needs two writes, not four.
// - Erase suspend allows other reads and programs.
// - Host may idle device into standby.
`timescale 1ns/1ps
module flash_host_ctrl
   import flash_host_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire cmd_t              cmd,
   output logic                   rsp_valid_q,
   output logic                   rsp_error_q,
   output logic [DATA_W-1:0]      rsp_data_q,
   output logic                   busy,
   output logic                   bypass_q,
   output logic                   erasing_q,
   output logic                   suspended_q,
   output pins_t                  flash_pins,
   output logic                   flash_reset_n,
   input  wire logic [DATA_W-1:0] data_lines,
   input  wire logic              operation_done_n_pin
);

   // Controller states, Gray coded along idle, write, poll.
   typedef enum logic [2:0] {S_IDLE = 3'b000, S_WRITE = 3'b001, S_POLL_A = 3'b011,
                             S_POLL_B = 3'b010, S_READ = 3'b110, S_HWRST = 3'b111} state_t;

   state_t            state_q;     // Current state.
   cmd_t              cmd_q;       // Order being carried out.
   logic [2:0]        idx_q;       // Index of the sequence write in progress.
   logic [2:0]        rst_cnt_q;   // Hardware reset pulse counter.
   logic              go_q;        // Start pulse to the bus cycle.
   logic              go_wr_q;     // Direction of the started cycle.
   bus_word_t         go_word_q;   // Word of the started cycle.
   logic              last_tog_q;  // Toggle bit seen by the previous poll read.
   logic              bus_done;    // Bus cycle finished.
   logic [DATA_W-1:0] bus_rdata;   // Byte of the last read cycle.
   logic              refuse;      // Order not legal in the current mode.
   logic              finish;      // Order completes this cycle.
   logic              ready_pin;   // Device reports not busy.
   logic [3:0]        wr_cnt_q;    // Writes issued for the current order.

   assign ready_pin = operation_done_n_pin;
   assign cmd_ready = (state_q == S_IDLE);
   assign busy      = (state_q != S_IDLE);

   // Legality of an order against the bypass, erase and suspend modes.
   always_comb
   begin
      refuse = 1'b0;
      case (cmd.op)
         OP_BYP_PROGRAM, OP_BYP_EXIT: refuse = !bypass_q;
         OP_READ, OP_HW_RESET, OP_WAIT_READY: refuse = 1'b0;
         OP_SUSPEND: refuse = bypass_q || !erasing_q || suspended_q;
         OP_RESUME:  refuse = bypass_q || !suspended_q;
         // Programming is refused in bypass and while an erase runs unsuspended.
         OP_PROGRAM: refuse = bypass_q || (erasing_q && !suspended_q);
         default:    refuse = bypass_q || erasing_q;
      endcase
   end

   // An order ends on its last bus cycle, its last poll read, or its reset pulse.
   always_comb
   begin
      finish = 1'b0;
      case (state_q)
         S_READ:   finish = bus_done;
         S_WRITE:  finish = bus_done && idx_q == seq_len(cmd_q.op) - 3'h1 &&
                            !(cmd_q.op inside {OP_PROGRAM, OP_BYP_PROGRAM, OP_SUSPEND});
         S_POLL_B: finish = bus_done && ready_pin &&
                            (bus_rdata[TOGGLE_BIT] == last_tog_q);
         S_HWRST:  finish = (rst_cnt_q == 3'(RESET_CYC - 1));
         default:  finish = 1'b0;
      endcase
   end

   // Main sequencer; it also issues each bus cycle as a one-cycle start pulse.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q   <= S_IDLE;
         cmd_q     <= '0;
         idx_q     <= 3'h0;
         go_q      <= 1'b0;
         go_wr_q   <= 1'b0;
         go_word_q <= '0;
      end
      else
      begin
         go_q <= 1'b0;
         case (state_q)
            S_IDLE:
               if (cmd_valid && !refuse)
               begin
                  cmd_q <= cmd;
                  idx_q <= 3'h0;
                  if (cmd.op == OP_HW_RESET) state_q <= S_HWRST;
                  else if (cmd.op == OP_READ || cmd.op == OP_WAIT_READY)
                  begin
                     state_q   <= (cmd.op == OP_READ) ? S_READ : S_POLL_A;
                     go_q      <= 1'b1;
                     go_wr_q   <= 1'b0;
                     go_word_q <= '{addr: cmd.addr, data: cmd.data};
                  end
                  else
                  begin
                     state_q   <= S_WRITE;
                     go_q      <= 1'b1;
                     go_wr_q   <= 1'b1;
                     go_word_q <= seq_word(cmd.op, 3'h0, cmd.addr, cmd.data);
                  end
               end
            S_WRITE:
               if (finish) state_q <= S_IDLE;
               else if (bus_done && idx_q == seq_len(cmd_q.op) - 3'h1)
               begin
                  // Program and suspend wait for the device by polling.
                  state_q   <= S_POLL_A;
                  go_q      <= 1'b1;
                  go_wr_q   <= 1'b0;
                  go_word_q <= '{addr: cmd_q.addr, data: cmd_q.data};
               end
               else if (bus_done)
               begin
                  idx_q     <= idx_q + 3'h1;
                  go_q      <= 1'b1;
                  go_word_q <= seq_word(cmd_q.op, idx_q + 3'h1, cmd_q.addr, cmd_q.data);
               end
            S_POLL_A, S_POLL_B:
               if (finish) state_q <= S_IDLE;
               else if (bus_done)
               begin
                  state_q <= S_POLL_B;
                  go_q    <= 1'b1;
               end
            S_READ, S_HWRST:
               if (finish) state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // The toggle bit of each poll read is kept to compare with the next one.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst) last_tog_q <= 1'b0;
      else if (bus_done) last_tog_q <= bus_rdata[TOGGLE_BIT];
   end

   // Reset pulse width counter; the pin is low for RESET_CYC cycles.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst) rst_cnt_q <= 3'h0;
      else if (state_q == S_HWRST) rst_cnt_q <= rst_cnt_q + 3'h1;
      else rst_cnt_q <= 3'h0;
   end

   assign flash_reset_n = (state_q != S_HWRST);

   // Mode flags follow the orders that complete; a hardware reset clears them all, a soft reset only bypass.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         bypass_q    <= 1'b0;
         erasing_q   <= 1'b0;
         suspended_q <= 1'b0;
      end
      else if (finish)
      begin
         case (cmd_q.op)
            OP_BYP_ENTER: bypass_q <= 1'b1;
            OP_BYP_EXIT:  bypass_q <= 1'b0;
            OP_CHIP_ERASE, OP_SECTOR_ERASE: erasing_q <= 1'b1;
            OP_SUSPEND:   suspended_q <= 1'b1;
            OP_RESUME:    suspended_q <= 1'b0;
            OP_WAIT_READY: if (!suspended_q) erasing_q <= 1'b0;
            OP_SOFT_RESET, OP_HW_RESET:
            begin
               bypass_q    <= 1'b0;
               erasing_q   <= (cmd_q.op == OP_SOFT_RESET) && erasing_q;
               suspended_q <= (cmd_q.op == OP_SOFT_RESET) && suspended_q;
            end
            default: bypass_q <= bypass_q;
         endcase
      end
   end

   // Answer: one pulse per order; a refused order answers at once with the error flag.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rsp_valid_q <= 1'b0;
         rsp_error_q <= 1'b0;
         rsp_data_q  <= '0;
      end
      else
      begin
         rsp_valid_q <= finish || (state_q == S_IDLE && cmd_valid && refuse);
         rsp_error_q <= (state_q == S_IDLE && cmd_valid && refuse);
         if (finish && (state_q == S_READ || state_q == S_POLL_B)) rsp_data_q <= bus_rdata;
      end
   end

   // Write cycles started for the current order, for checking sequence length.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst) wr_cnt_q <= 4'h0;
      else if (state_q == S_IDLE) wr_cnt_q <= 4'h0;
      else if (go_q && go_wr_q) wr_cnt_q <= wr_cnt_q + 4'h1;
   end

   flash_bus_cycle u_bus (
      .clock    (clock),
      .nrst     (nrst),
      .go       (go_q),
      .is_write (go_wr_q),
      .word     (go_word_q),
      .data_in  (data_lines),
      .pins     (flash_pins),
      .rdata_q  (bus_rdata),
      .done     (bus_done)
   );

   a_bypass_write_count: assert property (@(posedge clock) disable iff (!nrst)
      (state_q == S_POLL_A && $past(state_q) == S_WRITE) |->
      wr_cnt_q == ((cmd_q.op == OP_BYP_PROGRAM) ? 4'h2 : (cmd_q.op == OP_PROGRAM) ? 4'h4 : 4'h1))
      else $error("wrong number of program writes");
   a_standby_when_idle: assert property (@(posedge clock) disable iff (!nrst)
      (state_q == S_IDLE) [*2] |-> flash_pins.ce_n)
      else $error("chip select active while idle");
   sequence s_reset_pulse;
      !flash_reset_n [*5] ##1 flash_reset_n;
   endsequence
   a_reset_pulse_width: assert property (@(posedge clock) disable iff (!nrst)
      $fell(flash_reset_n) |-> s_reset_pulse)
      else $error("hardware reset pulse width wrong");
   a_suspend_read: assert property (@(posedge clock) disable iff (!nrst)
      (state_q == S_IDLE && cmd_valid && cmd.op == OP_READ && suspended_q) |=>
      state_q == S_READ)
      else $error("read refused during erase suspend");
   a_poll_waits_ready: assert property (@(posedge clock) disable iff (!nrst)
      (state_q == S_POLL_B && !ready_pin) |=> !rsp_valid_q)
      else $error("operation reported done while device busy");
   a_refuse_answer: assert property (@(posedge clock) disable iff (!nrst)
      (state_q == S_IDLE && cmd_valid && cmd.op == OP_BYP_PROGRAM && !bypass_q) |=>
      rsp_valid_q && rsp_error_q && state_q == S_IDLE)
      else $error("bypass program outside bypass not refused");
   a_order_taken: assert property (@(posedge clock) disable iff (!nrst)
      (state_q == S_IDLE && cmd_valid && !refuse && cmd.op == OP_PROGRAM) |=>
      go_q && go_wr_q && go_word_q.data == KEY_1 ##[1:40] (state_q == S_POLL_A))
      else $error("program sequence not issued");

endmodule

// ---- flash_host_pkg.sv ----
// Shared constants, types and sequence tables for the parallel flash host controller.
package flash_host_pkg;

   // Clock and bus timing; each phase of a bus cycle covers the slowest access time.
   localparam int CLK_NS     = 100;
   localparam int PHASE_NS   = 200;
   localparam int PHASE_CYC  = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   // Hardware reset pulse width, rounded up to whole cycles.
   localparam int RESET_NS   = 500;
   localparam int RESET_CYC  = (RESET_NS + CLK_NS - 1) / CLK_NS;

   // Array geometry: 262,144 byte locations on eight data lines.
   localparam int ADDR_W     = 18;
   localparam int DATA_W     = 8;
   localparam int TOGGLE_BIT = 6;

   // Unlock addresses and command codes written to the command register.
   localparam logic [17:0] UNLOCK_A1  = 18'h00555;
   localparam logic [17:0] UNLOCK_A2  = 18'h002aa;
   localparam logic [7:0]  KEY_1      = 8'haa;
   localparam logic [7:0]  KEY_2      = 8'h55;
   localparam logic [7:0]  CODE_PROG  = 8'ha0;
   localparam logic [7:0]  CODE_BYP   = 8'h20;
   localparam logic [7:0]  CODE_BEXIT = 8'h90;
   localparam logic [7:0]  CODE_BEX2  = 8'h00;
   localparam logic [7:0]  CODE_ERASE = 8'h80;
   localparam logic [7:0]  CODE_CHIP  = 8'h10;
   localparam logic [7:0]  CODE_SECT  = 8'h30;
   localparam logic [7:0]  CODE_SUSP  = 8'hb0;
   localparam logic [7:0]  CODE_RESM  = 8'h30;
   localparam logic [7:0]  CODE_RESET = 8'hf0;

   // Orders that the user side may give.
   typedef enum logic [3:0] {
      OP_READ, OP_PROGRAM, OP_BYP_ENTER, OP_BYP_PROGRAM, OP_BYP_EXIT, OP_CHIP_ERASE,
      OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_SOFT_RESET, OP_HW_RESET, OP_WAIT_READY
   } op_t;

   // One user order with its address and data.
   typedef struct packed {
      op_t               op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } cmd_t;

   // Device-facing strobes, address and data drive.
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic              dout_oe_n;
   } pins_t;

   // One address and data pair of a written command sequence.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } bus_word_t;

   // Number of write cycles that an order needs; zero for plain reads and waits.
   function automatic logic [2:0] seq_len(input op_t op);
      case (op)
         OP_PROGRAM:      seq_len = 3'h4;
         OP_BYP_ENTER:    seq_len = 3'h3;
         OP_BYP_PROGRAM:  seq_len = 3'h2;
         OP_BYP_EXIT:     seq_len = 3'h2;
         OP_CHIP_ERASE:   seq_len = 3'h6;
         OP_SECTOR_ERASE: seq_len = 3'h6;
         OP_SUSPEND:      seq_len = 3'h1;
         OP_RESUME:       seq_len = 3'h1;
         OP_SOFT_RESET:   seq_len = 3'h1;
         default:         seq_len = 3'h0;
      endcase
   endfunction

   // Address and data of write number idx of an order's sequence.
   function automatic bus_word_t seq_word(input op_t op, input logic [2:0] idx,
                                          input logic [ADDR_W-1:0] a,
                                          input logic [DATA_W-1:0] d);
      bus_word_t w;
      w = '{addr: a, data: d};
      case (op)
         OP_PROGRAM, OP_BYP_ENTER:
            if (idx == 3'h0) w = '{addr: UNLOCK_A1, data: KEY_1};
            else if (idx == 3'h1) w = '{addr: UNLOCK_A2, data: KEY_2};
            else if (idx == 3'h2)
               w = '{addr: UNLOCK_A1, data: (op == OP_PROGRAM) ? CODE_PROG : CODE_BYP};
         OP_BYP_PROGRAM:
            if (idx == 3'h0) w = '{addr: a, data: CODE_PROG};
         OP_BYP_EXIT:
            w = '{addr: a, data: (idx == 3'h0) ? CODE_BEXIT : CODE_BEX2};
         OP_CHIP_ERASE, OP_SECTOR_ERASE:
            if (idx == 3'h0 || idx == 3'h3) w = '{addr: UNLOCK_A1, data: KEY_1};
            else if (idx == 3'h1 || idx == 3'h4) w = '{addr: UNLOCK_A2, data: KEY_2};
            else if (idx == 3'h2) w = '{addr: UNLOCK_A1, data: CODE_ERASE};
            else if (op == OP_CHIP_ERASE) w = '{addr: UNLOCK_A1, data: CODE_CHIP};
            else w = '{addr: a, data: CODE_SECT};
         OP_SUSPEND:    w = '{addr: a, data: CODE_SUSP};
         OP_RESUME:     w = '{addr: a, data: CODE_RESM};
         OP_SOFT_RESET: w = '{addr: a, data: CODE_RESET};
         default:       w = '{addr: a, data: d};
      endcase
      return w;
   endfunction

endpackage

// ---- testbench.sv ----
// Self-checking bench for the flash host controller against the device model.
`timescale 1ns/1ps
module testbench
   import flash_host_pkg::*;
;
   logic              clock = 0, nrst = 0, cmd_valid = 0, slow = 0, low_supply = 0;
   cmd_t              cmd = '0;
   logic              cmd_ready, rsp_valid_q, rsp_error_q, busy, bypass_q;
   logic              erasing_q, suspended_q, flash_reset_n, ready_pin;
   logic [DATA_W-1:0] rsp_data_q, data_lines, d;
   logic [ADDR_W-1:0] a;
   pins_t             flash_pins;
   typedef struct packed {logic err; logic chk; logic [7:0] data;} note_t;
   note_t             notes [$]; // Expected answers in order of the orders.
   note_t             n;
   int                n_errors = 0, compares = 0, cycles = 0;

   always #50 clock = ~clock;

   flash_host_ctrl u_flash_host_ctrl (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid_q(rsp_valid_q), .rsp_error_q(rsp_error_q),
      .rsp_data_q(rsp_data_q), .busy(busy), .bypass_q(bypass_q), .erasing_q(erasing_q),
      .suspended_q(suspended_q), .flash_pins(flash_pins), .flash_reset_n(flash_reset_n),
      .data_lines(data_lines), .operation_done_n_pin(ready_pin));
   flash_dev_model u_flash_dev_model (.clock(clock), .pins(flash_pins), .reset_n(flash_reset_n),
      .slow(slow), .low_supply(low_supply), .data_lines(data_lines), .ready_pin(ready_pin));

   // Prints the counts and the verdict, then stops.
   task automatic end_sim;
      if (notes.size() != 0) n_errors++;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Gives one order, notes its expected answer, and waits for the answer plus a cycle.
   task automatic order(input op_t op, input logic [17:0] ad, input logic [7:0] dt,
                        input logic err, input logic ck, input logic [7:0] exp);
      notes.push_back('{err, ck, exp});
      while (cmd_ready !== 1'b1) @(posedge clock) #1;
      cmd = '{op, ad, dt};
      cmd_valid = 1;
      @(posedge clock) #1 cmd_valid = 0;
      chk(busy, !err);
      while (rsp_valid_q !== 1'b1) @(posedge clock) #1;
      @(posedge clock) #1;
   endtask

   // Compares a settled mode flag, or busy just after an order is given.
   task automatic chk(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Watches answers, matches them to the oldest note, and cuts a hang short.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         n_errors++;
         end_sim();
      end
      else if (rsp_valid_q === 1'b1)
      begin
         n = (notes.size() != 0) ? notes.pop_front() : '1;
         compares++;
         if (rsp_error_q !== n.err || (n.chk && rsp_data_q !== n.data))
         begin
            n_errors++;
            $display("unexpected at %0t: got %h %h expected %h %h", $time, rsp_error_q,
                     rsp_data_q, n.err, n.data);
         end
      end
   end

   // Main sequence: reads, normal and bypass programs, erases with suspend, resets.
   initial
   begin
      void'($urandom(95));
      repeat (12) @(posedge clock);
      #1 nrst = 1;
      a = {2'h1, 15'($urandom), 1'b0};
      d = 8'($urandom);
      order(OP_READ, 18'h01234, 8'h00, 0, 1, 8'hff);
      order(OP_PROGRAM, a, d, 0, 0, 8'h00);
      order(OP_READ, a, 8'h00, 0, 1, d);
      order(OP_PROGRAM, 18'h20000, 8'h00, 0, 0, 8'h00);
      order(OP_READ, 18'h20000, 8'h00, 0, 1, 8'hff);
      low_supply = 1;
      order(OP_PROGRAM, 18'h30012, 8'h00, 0, 0, 8'h00);
      low_supply = 0;
      order(OP_READ, 18'h30012, 8'h00, 0, 1, 8'hff);
      order(OP_BYP_PROGRAM, a, d, 1, 0, 8'h00);
      order(OP_BYP_ENTER, a, 8'h00, 0, 0, 8'h00);
      chk(bypass_q, 1'b1);
      order(OP_PROGRAM, a, d, 1, 0, 8'h00);
      slow = 1;
      order(OP_BYP_PROGRAM, a + 18'h1, ~d, 0, 0, 8'h00);
      order(OP_READ, a + 18'h1, 8'h00, 0, 1, ~d);
      order(OP_BYP_EXIT, a, 8'h00, 0, 0, 8'h00);
      chk(bypass_q, 1'b0);
      order(OP_PROGRAM, 18'h30010, 8'h5a, 0, 0, 8'h00);
      order(OP_SUSPEND, a, 8'h00, 1, 0, 8'h00);
      order(OP_SECTOR_ERASE, a, 8'h00, 0, 0, 8'h00);
      chk(erasing_q, 1'b1);
      order(OP_SECTOR_ERASE, a, 8'h00, 1, 0, 8'h00);
      order(OP_PROGRAM, 18'h30011, 8'h3c, 1, 0, 8'h00);
      order(OP_SUSPEND, a, 8'h00, 0, 0, 8'h00);
      chk(suspended_q, 1'b1);
      order(OP_PROGRAM, 18'h30011, 8'h3c, 0, 0, 8'h00);
      order(OP_READ, 18'h30010, 8'h00, 0, 1, 8'h5a);
      order(OP_RESUME, a, 8'h00, 0, 0, 8'h00);
      chk(suspended_q, 1'b0);
      order(OP_RESUME, a, 8'h00, 1, 0, 8'h00);
      order(OP_WAIT_READY, a, 8'h00, 0, 0, 8'h00);
      chk(erasing_q, 1'b0);
      order(OP_READ, a, 8'h00, 0, 1, 8'hff);
      order(OP_READ, 18'h30011, 8'h00, 0, 1, 8'h3c);
      order(OP_CHIP_ERASE, a, 8'h00, 0, 0, 8'h00);
      order(OP_HW_RESET, a, 8'h00, 0, 0, 8'h00);
      chk(erasing_q, 1'b0);
      order(OP_SOFT_RESET, a, 8'h00, 0, 0, 8'h00);
      slow = 0;
      order(OP_CHIP_ERASE, a, 8'h00, 0, 0, 8'h00);
      order(OP_WAIT_READY, a, 8'h00, 0, 0, 8'h00);
      order(OP_READ, 18'h30010, 8'h00, 0, 1, 8'hff);
      end_sim();
   end
endmodule
